// ==== common/pmtc_cfg.svh ====
// How it works
// - timer register low 24 bits give the live count; bits 31:24 reserved, read zero.
// - counter steps on a 3.579545 MHz tick, the 14.31818 MHz reference divided by four.
// - counter clears under reset, then counts while the system stays in S0.
// - bit 22 falling from one to zero sets the overflow flag.
// - overflow flag plus its enable raises the system-control interrupt.
// - throttle-active flag reads one while stop-clock throttling is in effect.
// - force-throttle bit starts thermal throttling, like a held thermal alarm; clear ends it.
// - bits 7:5 select the thermal throttle duty cycle.
// - stop-clock asserted for the selected share of each 1024-clock period.
// - throttling happens only in C0, never in C2.
// - thermal throttling has no enable; an alarm always throttles in C0.
// - duty field accepts only its first write after reset.
// - control register resets to zero; timer low bits reset to zero.
// - software throttle enable in C0 throttles at the selected duty cycle.
`ifndef PMTC_CFG_SVH
`define PMTC_CFG_SVH
`define PMTC_TMR_OFS 8'h08
`define PMTC_CNT_OFS 8'h10
`define PMTC_CNT_RST 32'h00000000
`define PMTC_TMR_MSB 23
`define PMTC_OVF_BIT 22
`define PMTC_STS_BIT 17
`define PMTC_FORCE_BIT 8
`define PMTC_DTY_LSB 5
`define PMTC_DTY_MSB 7
`define PMTC_SWEN_BIT 4
`define PMTC_REF_DIV 2'h3
`define PMTC_PERIOD_BITS 10
`define PMTC_DUTY_STEP 11'h080
`define PMTC_PERIOD_CNT 11'h400
`define PMTC_HALF_CNT 10'h200
`endif

// ==== common/pmtc_pkg.sv ====
package pmtc_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pmtc_req_t;
  typedef enum logic [1:0] {PMTC_C0, PMTC_C2, PMTC_C3} pmtc_cstate_t;
endpackage

// ==== rtl/pmtc_duty_gen.sv ====
`include "pmtc_cfg.svh"
module pmtc_duty_gen
  import pmtc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [2:0] dutySel,
  output logic stopActive
);
  logic [9:0] phase_ff;
  logic [9:0] highCnt;
  always_comb
  begin
    // code 000 behaves as 50%; others step 12.5% downward from 87.5%
    if (dutySel == 3'h0)
      highCnt = `PMTC_HALF_CNT;
    else
      highCnt = 10'(`PMTC_PERIOD_CNT - 11'(dutySel) * `PMTC_DUTY_STEP);
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_ff <= 10'h000;
    else if (!run)
      phase_ff <= 10'h000;
    else
      phase_ff <= phase_ff + 10'h001;
  end
  assign stopActive = run && (phase_ff < highCnt);
endmodule

// ==== rtl/pm_timer_throttle.sv ====
`include "pmtc_cfg.svh"
module pm_timer_throttle
  import pmtc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic refClk,
  input wire logic inS0,
  input wire pmtc_cstate_t cState,
  input wire logic thermalAlarm_n,
  input wire pmtc_req_t req,
  output logic [31:0] rdata,
  output logic sciIrq,
  output logic timerOverflowFlag,
  output logic stopClock_n
);
  logic [2:0] refSync_ff;
  logic [1:0] refDiv_ff;
  logic tick;
  logic [23:0] count_ff;
  logic ovfFlag_ff;
  logic ovfEn_ff;
  logic force_ff;
  logic swEn_ff;
  logic [2:0] duty_ff;
  logic dutyLocked_ff;
  logic [31:0] rdata_ff;
  logic throttleRun;
  logic stopActive;
  logic wrCnt;
  logic wrTmr;
  logic ovfFall;

  // two-stage sync, then edge detect on the second and third stages
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      refSync_ff <= 3'h0;
    else
      refSync_ff <= {refSync_ff[1:0], refClk};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      refDiv_ff <= 2'h0;
    else if (refSync_ff[1] && !refSync_ff[2])
      refDiv_ff <= refDiv_ff + 2'h1;
  end
  // 25 MHz clock samples a 14.3 MHz reference only approximately; real silicon needs a faster clock
  assign tick = refSync_ff[1] && !refSync_ff[2] && (refDiv_ff == `PMTC_REF_DIV);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      count_ff <= 24'h000000;
    else if (tick && inS0)
      count_ff <= count_ff + 24'h000001;
  end

  assign ovfFall = tick && inS0 && count_ff[`PMTC_OVF_BIT] &&
                   (count_ff[`PMTC_OVF_BIT-1:0] == 22'h3fffff);

  assign wrCnt = req.wr && (req.addr == `PMTC_CNT_OFS);
  assign wrTmr = req.wr && (req.addr == `PMTC_TMR_OFS);

  // overflow flag is write-one-to-clear at the timer offset; bit 0 enables the interrupt
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ovfFlag_ff <= 1'b0;
    else if (ovfFall)
      ovfFlag_ff <= 1'b1;
    else if (wrTmr && req.wdata[`PMTC_OVF_BIT])
      ovfFlag_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ovfEn_ff <= 1'b0;
    else if (wrTmr)
      ovfEn_ff <= req.wdata[0];
  end

  assign sciIrq = ovfFlag_ff && ovfEn_ff;
  assign timerOverflowFlag = ovfFlag_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      force_ff <= 1'b0;
      swEn_ff <= 1'b0;
    end
    else if (wrCnt)
    begin
      force_ff <= req.wdata[`PMTC_FORCE_BIT];
      swEn_ff <= req.wdata[`PMTC_SWEN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      duty_ff <= 3'h0;
      dutyLocked_ff <= 1'b0;
    end
    else if (wrCnt && !dutyLocked_ff)
    begin
      duty_ff <= req.wdata[`PMTC_DTY_MSB:`PMTC_DTY_LSB];
      dutyLocked_ff <= 1'b1;
    end
  end

  // thermal path has no enable: alarm or force always throttles in C0
  assign throttleRun = (cState == PMTC_C0) &&
                       (!thermalAlarm_n || force_ff || swEn_ff);

  pmtc_duty_gen u_duty (
    .clk(clk),
    .rstn(rstn),
    .run(throttleRun),
    .dutySel(duty_ff),
    .stopActive(stopActive)
  );

  assign stopClock_n = !stopActive;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= 32'h00000000;
    else if (req.rd)
    begin
      unique case (req.addr)
        `PMTC_TMR_OFS: rdata_ff <= {8'h00, count_ff};
        `PMTC_CNT_OFS: rdata_ff <= {14'h0000, throttleRun, 8'h00, force_ff,
                                    duty_ff, swEn_ff, 4'h0};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end
  assign rdata = rdata_ff;
endmodule

// ==== tb/pmtc_host_model.sv ====
module pmtc_host_model
(
  input wire logic clk,
  input wire logic stopClock_n,
  input wire logic clr,
  output int lowCount
);
  timeunit 1ns;
  timeprecision 1ns;
  // stop-grant cycles seen since the last clear
  always @(posedge clk)
    lowCount <= clr ? 0 : lowCount + int'(!stopClock_n);
endmodule

// ==== tb/pmtc_chk.sv ====
module pmtc_chk
  import pmtc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire pmtc_cstate_t cState,
  input wire pmtc_req_t req,
  input wire logic [31:0] rdata,
  input wire logic sciIrq,
  input wire logic timerOverflowFlag,
  input wire logic stopClock_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_stop_c2: assert property ((cState != PMTC_C0) [*3] |-> stopClock_n)
    else $error("stop outside C0");
  a_sci_flag: assert property (sciIrq |-> timerOverflowFlag)
    else $error("irq without flag");
  a_rd_hold: assert property (!req.rd |=> $stable(rdata))
    else $error("rdata moved");
  a_unmapped_zero: assert property (req.rd && req.addr[3:0] == 4'h0 && req.addr != 8'h10
    |=> rdata == 32'h0)
    else $error("unmapped data");
  a_tmr_top: assert property (req.rd && req.addr == 8'h08 |=> rdata[31:24] == 8'h0)
    else $error("timer top byte");
  a_ctl_rsvd: assert property (req.rd && req.addr == 8'h10
    |=> rdata[31:18] == 14'h0 && rdata[16:9] == 8'h0 && rdata[3:0] == 4'h0)
    else $error("reserved bits");
  a_flag_keep: assert property (timerOverflowFlag && !req.wr |=> timerOverflowFlag)
    else $error("flag lost");
  a_rst_stop: assert property ($rose(rstn) |-> stopClock_n && !sciIrq)
    else $error("reset outputs");
  cover property (!stopClock_n);
  cover property (req.wr && req.addr == 8'h10);
  cover property (req.rd && req.addr == 8'h08);
endmodule
bind pm_timer_throttle pmtc_chk i_chk (.clk, .rstn, .cState, .req, .rdata, .sciIrq,
  .timerOverflowFlag, .stopClock_n);

// ==== tb/testbench.sv ====
module testbench;
  import pmtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d;} pmtc_row_t;
  logic clk = 0, rstn = 0, refClk = 0, inS0 = 0, thermalAlarm_n = 1, clr = 0;
  pmtc_cstate_t cState = PMTC_C0;
  pmtc_req_t req = '0;
  logic [31:0] rdata, t0;
  logic sciIrq, timerOverflowFlag, stopClock_n;
  int lowCount, failures = 0, checks = 0;
  // reads carry the expected value in d
  pmtc_row_t rows[7] = '{'{0, 8'h10, 0}, '{0, 8'h08, 0}, '{0, 8'h20, 0}, '{1, 8'h10, 32'h1e0},
    '{0, 8'h10, 32'h201e0}, '{1, 8'h10, 32'h20}, '{0, 8'h10, 32'he0}};
  always #20 clk = ~clk;
  // reference scaled down: a 25 MHz sampler would alias the real 14.3 MHz edges
  always #140 refClk = ~refClk;
  pm_timer_throttle i_dut (.clk, .rstn, .refClk, .inS0, .cState, .thermalAlarm_n, .req,
    .rdata, .sciIrq, .timerOverflowFlag, .stopClock_n);
  pmtc_host_model i_host (.clk, .stopClock_n, .clr, .lowCount);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk(rdata, e);
  endtask
  // a 1024-cycle window holds one whole throttle period at any phase
  task automatic duty(input logic [31:0] e);
    repeat (4) @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (1024) @(posedge clk);
    #1 chk(lowCount, e);
  endtask
  task automatic end_sim;
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    foreach (rows[i])
      if (rows[i].w)
        acc(1, rows[i].a, rows[i].d);
      else
        rd(rows[i].a, rows[i].d);
    acc(1, 8'h10, 32'h100);
    duty(32'h80);
    cState <= PMTC_C2;
    duty(32'h0);
    cState <= PMTC_C0;
    acc(1, 8'h10, 32'h0);
    thermalAlarm_n <= 0;
    duty(32'h80);
    thermalAlarm_n <= 1;
    inS0 <= 1;
    acc(0, 8'h08, 0);
    t0 = rdata;
    repeat (700) @(posedge clk);
    acc(0, 8'h08, 0);
    chk(32'((rdata - t0 >= 32'h18) && (rdata - t0 <= 32'h1a)), 32'h1);
    inS0 <= 0;
    repeat (8) @(posedge clk);
    acc(0, 8'h08, 0);
    t0 = rdata;
    repeat (50) @(posedge clk);
    rd(8'h08, t0);
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(8'h08, 32'h0);
    acc(1, 8'h10, 32'h40);
    acc(1, 8'h10, 32'h80);
    rd(8'h10, 32'h40);
    acc(1, 8'h10, 32'h10);
    duty(32'h300);
    rd(8'h10, 32'h20050);
    acc(1, 8'h08, 32'h1);
    chk(32'(sciIrq), 32'h0);
    chk(32'(timerOverflowFlag), 32'h0);
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    acc(1, 8'h10, 32'h110);
    duty(32'h200);
    end_sim();
  end
endmodule
